// file: logic/cfbp_router.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfbp_consts.svh"
// Overview of operation
// - matched message goes to filter's pointed buffer
// - code 0000 buffer 0, 0001 buffer 1
// - filter7 bits 15-12, filter6 bits 11-8
// - filter5 bits 7-4, filter4 bits 3-0
// - filters 11..8 at 15-12 down to 3-0
// - filters 3..0 likewise; fields RW, reset zero
// - disabled filter accepts nothing
module cfbp_router
   import cfbp_pkg::*;
(
   input  wire logic                       ref_clk_i,
   input  wire logic                       rst_i,
   input  wire logic [`CFBP_ADDR_W-1:0]    addr_i,
   input  wire logic [`CFBP_REG_W-1:0]     wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [`CFBP_REG_W-1:0]     rdata_o,
   input  wire cfbp_pkg::cfbp_hit_t        hit_i,
   output cfbp_pkg::cfbp_route_t           route_o
);
   import cfbp_pkg::*;

   localparam int NREG = `CFBP_NUM_FILT / `CFBP_FILT_PER_REG;

   logic [`CFBP_REG_W-1:0]     ptr_reg [NREG];
   logic [`CFBP_NUM_FILT-1:0]  enable_r;
   logic [`CFBP_PTR_W-1:0]     target  [`CFBP_NUM_FILT];
   logic [3:0]                 hit_cnt_r;
   logic [`CFBP_PTR_W-1:0]     sel_ptr;
   logic                       sel_en;

   ////////////////////////////////////////////////////////////////////////
   // pointer registers, one per group of four filters
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         cfbp_ptr_field #(
            .REG_W   (`CFBP_REG_W)
         ) u_field (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .wr_i      (wr_i && (addr_i == 4'(g))),
            .wdata_i   (wdata_i),
            .value_o   (ptr_reg[g])
         );
      end
      // filter n lives in register n/4, nibble n%4 (higher filter, higher bits)
      for (g = 0; g < `CFBP_NUM_FILT; g++) begin : g_fld
         assign target[g] = ptr_reg[g/4][(g%4)*4 +: 4];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // filter accept enables, all set after reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_r <= `CFBP_ENABLE_RST;
      end else if (wr_i && addr_i == `CFBP_IDX_ENABLE) begin
         enable_r <= wdata_i[`CFBP_NUM_FILT-1:0];
      end
   end

   // select pointer and enable of the hitting filter
   always_comb begin
      sel_ptr = `CFBP_PTR_BUF0;
      sel_en  = 1'b0;
      if (hit_i.filter < 4'(`CFBP_NUM_FILT)) begin
         sel_ptr = target[hit_i.filter];
         sel_en  = enable_r[hit_i.filter];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // routing decision, registered
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         route_o <= '0;
      end else begin
         route_o.valid   <= hit_i.valid && sel_en;
         route_o.to_fifo <= (sel_ptr == `CFBP_PTR_FIFO);
         route_o.buffer  <= sel_ptr;
         route_o.filter  <= hit_i.filter;
      end
   end

   // count of routed messages, wraps
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hit_cnt_r <= 4'h0;
      end else if (hit_i.valid && sel_en) begin
         hit_cnt_r <= hit_cnt_r + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            `CFBP_IDX_PTR_0_3:  rdata_o <= ptr_reg[0];
            `CFBP_IDX_PTR_4_7:  rdata_o <= ptr_reg[1];
            `CFBP_IDX_PTR_8_11: rdata_o <= ptr_reg[2];
            `CFBP_IDX_ENABLE:   rdata_o <= {4'h0, enable_r};
            `CFBP_IDX_STATUS:   rdata_o <= {12'h000, hit_cnt_r};
            default:            rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end
endmodule : cfbp_router
`default_nettype wire

// file: logic/cfbp_consts.svh
`ifndef CFBP_CONSTS_SVH
`define CFBP_CONSTS_SVH
// register indices (word addresses on the plain register port)
`define CFBP_ADDR_W         4
`define CFBP_IDX_PTR_0_3    4'h0
`define CFBP_IDX_PTR_4_7    4'h1
`define CFBP_IDX_PTR_8_11   4'h2
`define CFBP_IDX_ENABLE     4'h3
`define CFBP_IDX_STATUS     4'h4
// field layout
`define CFBP_PTR_W          4
`define CFBP_REG_W          16
`define CFBP_NUM_FILT       12
`define CFBP_FILT_PER_REG   4
// reset values
`define CFBP_PTR_RST        16'h0000
`define CFBP_ENABLE_RST     12'hFFF
// pointer codes
`define CFBP_PTR_FIFO       4'hF
`define CFBP_PTR_BUF0       4'h0
`endif

// file: logic/cfbp_pkg.sv
`include "cfbp_consts.svh"
package cfbp_pkg;
   // accepted-message routing request
   typedef struct packed {
      logic                     valid;
      logic [3:0]               filter;
   } cfbp_hit_t;
   // routing decision toward the buffer store
   typedef struct packed {
      logic                     valid;
      logic                     to_fifo;
      logic [`CFBP_PTR_W-1:0]   buffer;
      logic [3:0]               filter;
   } cfbp_route_t;
endpackage : cfbp_pkg

// file: logic/cfbp_ptr_field.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfbp_consts.svh"
// one 16-bit register holding four 4-bit target-buffer pointers
module cfbp_ptr_field #(
   parameter int REG_W = 16
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             wr_i,
   input  wire logic [REG_W-1:0] wdata_i,
   output logic      [REG_W-1:0] value_o
);
   // all fields read/write, cleared at reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         value_o <= `CFBP_PTR_RST;
      end else if (wr_i) begin
         value_o <= wdata_i;
      end
   end
endmodule : cfbp_ptr_field
`default_nettype wire

// file: dv/cfbp_can_node.sv
`timescale 1ns/10ps
`default_nettype none
// remote node: each send is one accepted frame
module cfbp_can_node (
   input  wire logic           ref_clk_i,
   output var cfbp_pkg::cfbp_hit_t hit_o
);
   initial hit_o = '0;
   task automatic send(input logic [3:0] f);
      @(posedge ref_clk_i);
      hit_o <= {1'b1, f};
      @(posedge ref_clk_i);
      hit_o <= {1'b0, ~f}; // stale index scrambled
   endtask : send
endmodule : cfbp_can_node
`default_nettype wire

// file: dv/cfbp_router_props.sv
`timescale 1ns/10ps
`default_nettype none
// router port checks
module cfbp_router_props (
   input wire logic ref_clk_i, rst_i, wr_i, rd_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i, rdata_o,
   input wire cfbp_pkg::cfbp_hit_t hit_i,
   input wire cfbp_pkg::cfbp_route_t route_o);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_h0; !wr_i ##1 hit_i == 5'h10; endsequence
   property p_rd; !rd_i |=> rdata_o == 16'h0000; endproperty
   a_rd: assert property (p_rd) else $error("read data");
   property p_rw; wr_i && addr_i < 3 ##1 !wr_i ##1 rd_i && addr_i == $past(addr_i, 2)
      |=> rdata_o == $past(wdata_i, 3); endproperty
   a_rw: assert property (p_rw) else $error("readback");
   property p_pt; wr_i && addr_i == 0 ##1 s_h0 |=> route_o.buffer == $past(wdata_i[3:0], 3);
      endproperty
   a_pt: assert property (p_pt) else $error("pointer");
   property p_of; wr_i && addr_i == 3 && !wdata_i[0] ##1 s_h0 |=> !route_o.valid; endproperty
   a_of: assert property (p_of) else $error("disabled");
   property p_bg; hit_i.valid && hit_i.filter > 11 |=> !route_o.valid; endproperty
   a_bg: assert property (p_bg) else $error("range");
   property p_id; !hit_i.valid |=> !route_o.valid; endproperty
   a_id: assert property (p_id) else $error("idle");
   property p_fl; route_o.valid |-> route_o.filter == $past(hit_i.filter); endproperty
   a_fl: assert property (p_fl) else $error("filter");
   property p_ff; route_o.valid |-> route_o.to_fifo == &route_o.buffer; endproperty
   a_ff: assert property (p_ff) else $error("fifo");
endmodule : cfbp_router_props
bind cfbp_router cfbp_router_props u_props (.ref_clk_i, .rst_i, .wr_i, .rd_i, .addr_i,
   .wdata_i, .rdata_o, .hit_i, .route_o);
`default_nettype wire

// file: dv/cfbp_router_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cfbp_router_tb;
   import cfbp_pkg::*;
   logic        ref_clk_i = 1'b0, rst_i, wr_i, rd_i;
   logic [3:0]  addr_i, p;
   logic [15:0] wdata_i, rdata_o, q;
   logic [15:0] w [3] = '{16'h1F20, 16'h7654, 16'hBA98};
   cfbp_hit_t   hit_i;
   cfbp_route_t route_o;
   int          bad_count, total_checks;
   cfbp_router dut (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .hit_i,
      .route_o);
   cfbp_can_node node (.ref_clk_i, .hit_o(hit_i));
   initial forever #20 ref_clk_i = ~ref_clk_i;
   task automatic chk(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) bad_count++;
      if (got !== exp) $display("wrong value at %0t: %h not %h", $time, got, exp);
   endtask : chk
   // one write or read cycle, read data kept in q
   task automatic bus(input logic we, input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      {wr_i, rd_i, addr_i, wdata_i} <= {we, !we, a, d};
      @(posedge ref_clk_i);
      {wr_i, rd_i} <= 2'b00;
      #1 q = rdata_o;
   endtask : bus
   task automatic t_regs;
      for (int a = 0; a < 6; a++) begin
         bus(1'b0, 4'(a), 16'h0000);
         chk(q, a == 3 ? 16'h0FFF : 16'h0000);
         if (a < 3) bus(1'b1, 4'(a), w[a]);
         if (a < 3) bus(1'b0, 4'(a), 16'h0000);
         if (a < 3) chk(q, w[a]);
      end
      $display("register test done");
   endtask : t_regs
   task automatic t_route;
      for (int f = 0; f < 12; f++) begin
         p = w[f/4][f%4*4 +: 4];
         node.send(4'(f));
         #1 chk(route_o, {1'b1, p == 4'hF, p, 4'(f)});
      end
      $display("routing test done");
   endtask : t_route
   task automatic t_enable;
      bus(1'b1, 4'h0, 16'h1F23);
      node.send(4'h0);
      #1 chk(route_o.buffer, 4'h3);
      bus(1'b1, 4'h3, 16'h0FFE);
      for (int f = 0; f < 3; f++) begin
         node.send(f == 2 ? 4'hC : 4'(f));
         #1 chk(route_o.valid, f == 1);
      end
      // routed count: 12 + 2 accepted, disabled and out-of-range hits not counted
      bus(1'b0, 4'h4, 16'h0000);
      chk(q, 16'h000E);
      $display("enable test done");
   endtask : t_enable
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   initial begin
      {rst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 22'h0};
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_route;
      t_enable;
      complete_run;
   end
   // hang guard
   initial begin
      #20000 bad_count++;
      complete_run;
   end
endmodule : cfbp_router_tb
`default_nettype wire
